// ### design/lwc_wake_config.sv
// Wake configuration registers and low-power wake logic behind the serial port
`timescale 1ns/1ps
module lwc_wake_config
	import lwc_pkg::*;
#(
	parameter int MS_CYCLES_P = MS_CYCLES,
	parameter int LP_CLK_P = LP_CLK_CYCLES
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sclkPin,
	input wire logic csPinN,
	input wire logic mosiPin,
	output logic miso,
	output logic misoOe,
	input wire logic faultStatus,
	input wire logic interruptFlag,
	input wire logic lowPowerReq,
	input wire logic [PROG_CH-1:0] progSwitchPin,
	input wire logic [GND_CH-1:0] gndSwitchPin,
	output lwc_mode_e lowPowerState,
	output logic wakeEvent,
	output logic pollTimerRun,
	output logic pollStrobe,
	output logic [CHANNELS-1:0] pollCurrentEn,
	output logic [CHANNELS-1:0] comparatorEn
);
	lwc_cmd_s cmd;
	logic cmdValid;
	logic [FRAME_BITS-1:0] respWord;
	logic [PROG_CH-1:0] wakeProg, next_wakeProg, compProg, next_compProg;
	logic [GND_CH-1:0] wakeGnd, next_wakeGnd, compGnd, next_compGnd;
	logic [3:0] pollRate, next_pollRate;
	logic [ADDR_BITS-1:0] prevAddr, next_prevAddr;
	logic prevWrite, next_prevWrite;
	logic [CHANNELS-1:0] chanMeta, chanSync, refState, next_refState;
	logic [CHANNELS-1:0] wakeAll, compAll, diff, next_pollCurrentEn, next_comparatorEn;
	logic [POLL_BITS-1:0] pollCount, next_pollCount, periodCycles;
	logic [15:0] lpCount, next_lpCount;
	lwc_mode_e next_state;
	logic anyWake, pollHit, lpTick, pollWake, compWake;
	logic next_wakeEvent, next_pollTimerRun, next_pollStrobe;
	logic isWrite;

	// Register read decode; unused upper bits come back zero
	function automatic logic [REG_DATA_BITS-1:0] lwc_read_data(
		input logic [ADDR_BITS-1:0] a
	);
		logic [REG_DATA_BITS-1:0] r;
		r = '0;
		case (a)
			ADDR_POLL_CFG: r = REG_DATA_BITS'(pollRate);
			ADDR_WAKE_PROG: r = REG_DATA_BITS'(wakeProg); // RQ10
			ADDR_WAKE_GND: r = REG_DATA_BITS'(wakeGnd); // RQ10
			ADDR_COMP_PROG: r = REG_DATA_BITS'(compProg);
			ADDR_COMP_GND: r = REG_DATA_BITS'(compGnd);
			default: r = '0;
		endcase
		return r;
	endfunction : lwc_read_data

	lwc_spi_frame u_frame (
		.core_clk(core_clk),
		.resetn(resetn),
		.sclkPin(sclkPin),
		.csPinN(csPinN),
		.mosiPin(mosiPin),
		.respWord(respWord),
		.cmd(cmd),
		.cmdValid(cmdValid),
		.miso(miso),
		.misoOe(misoOe)
	);

	// Response echoes the previous command's register with live status flags
	assign respWord = {prevAddr, prevWrite, faultStatus, interruptFlag,
		lwc_read_data(prevAddr)}; // RQ9
	assign isWrite = cmdValid && cmd.write;

	// Register writes are taken in any mode, including mid low-power request
	always_comb
	begin
		next_wakeProg = wakeProg;
		next_wakeGnd = wakeGnd;
		next_compProg = compProg;
		next_compGnd = compGnd;
		next_pollRate = pollRate;
		next_prevAddr = prevAddr;
		next_prevWrite = prevWrite;
		if (cmdValid)
		begin
			next_prevAddr = cmd.addr;
			next_prevWrite = cmd.write;
		end
		if (isWrite)
		begin
			case (cmd.addr)
				ADDR_POLL_CFG: next_pollRate = cmd.data[3:0]; // RQ11
				ADDR_WAKE_PROG: next_wakeProg = cmd.data[PROG_CH-1:0]; // RQ3
				ADDR_WAKE_GND: next_wakeGnd = cmd.data[GND_CH-1:0]; // RQ3
				ADDR_COMP_PROG: next_compProg = cmd.data[PROG_CH-1:0];
				ADDR_COMP_GND: next_compGnd = cmd.data[GND_CH-1:0];
				default: next_pollRate = pollRate;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wakeProg <= RST_WAKE_PROG; // RQ4
			wakeGnd <= RST_WAKE_GND; // RQ4
			compProg <= RST_COMP_PROG;
			compGnd <= RST_COMP_GND;
			pollRate <= RST_POLL_RATE; // RQ11
			prevAddr <= '0;
			prevWrite <= 1'b0;
		end
		else
		begin
			wakeProg <= next_wakeProg;
			wakeGnd <= next_wakeGnd;
			compProg <= next_compProg;
			compGnd <= next_compGnd;
			pollRate <= next_pollRate;
			prevAddr <= next_prevAddr;
			prevWrite <= next_prevWrite;
		end
	end

	// Wake qualifiers
	assign wakeAll = {wakeGnd, wakeProg};
	assign compAll = {compGnd, compProg};
	assign diff = chanSync ^ refState;
	assign anyWake = |wakeAll;
	assign periodCycles = POLL_BITS'(POLL_MS[pollRate] * MS_CYCLES_P); // RQ11
	assign lpTick = lpCount == 16'(LP_CLK_P - 1);
	// Compare is >= so a shorter rate written mid-period cannot leave the timer running to wrap
	assign pollHit = lowPowerState == MODE_LOWPOWER && anyWake
		&& pollCount >= periodCycles - 23'h000001; // RQ5
	assign pollWake = pollHit && |(diff & wakeAll & ~compAll); // RQ1 RQ2
	assign compWake = lowPowerState == MODE_LOWPOWER && lpTick
		&& |(diff & wakeAll & compAll); // RQ7 RQ1

	// Low-power sequencing; reference states are taken on entry
	always_comb
	begin
		next_state = lowPowerState;
		next_refState = refState;
		next_pollCount = pollCount;
		next_lpCount = lpTick ? 16'h0000 : lpCount + 16'h0001;
		next_wakeEvent = 1'b0;
		next_pollStrobe = pollHit;
		case (lowPowerState)
			MODE_NORMAL:
			begin
				next_pollCount = '0;
				if (lowPowerReq)
				begin
					next_state = MODE_LOWPOWER;
					next_refState = chanSync;
				end
			end
			MODE_LOWPOWER:
			begin
				// Timer cleared to zero when nothing may wake, and restarted after each poll
				if (!anyWake || pollHit)
					next_pollCount = '0; // RQ5
				else
					next_pollCount = pollCount + 23'h000001;
				if (pollWake || compWake)
				begin
					next_state = MODE_NORMAL; // RQ2
					next_wakeEvent = 1'b1;
				end
				else if (!lowPowerReq)
					next_state = MODE_NORMAL;
			end
			default: next_state = MODE_NORMAL;
		endcase
		next_pollTimerRun = next_state == MODE_LOWPOWER && anyWake; // RQ5
		next_comparatorEn = next_state == MODE_LOWPOWER ? compAll : '0; // RQ6
		next_pollCurrentEn = pollHit ? ~compAll : '0; // RQ6
	end

	// Low-power state registers and pin synchroniser
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			chanMeta <= '0;
			chanSync <= '0;
			lowPowerState <= MODE_NORMAL;
			refState <= '0;
			pollCount <= '0;
			lpCount <= '0;
			wakeEvent <= 1'b0;
			pollStrobe <= 1'b0;
			pollTimerRun <= 1'b0;
			comparatorEn <= '0;
			pollCurrentEn <= '0;
		end
		else
		begin
			chanMeta <= {gndSwitchPin, progSwitchPin};
			chanSync <= chanMeta;
			lowPowerState <= next_state;
			refState <= next_refState;
			pollCount <= next_pollCount;
			lpCount <= next_lpCount;
			wakeEvent <= next_wakeEvent;
			pollStrobe <= next_pollStrobe;
			pollTimerRun <= next_pollTimerRun;
			comparatorEn <= next_comparatorEn;
			pollCurrentEn <= next_pollCurrentEn;
		end
	end

	// Helper for interval check: cycles since the last poll strobe
	logic [POLL_BITS-1:0] gapCnt;
	logic gapValid;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gapCnt <= '0;
			gapValid <= 1'b0;
		end
		else
		begin
			gapCnt <= pollStrobe ? '0 : gapCnt + 23'h000001;
			if (lowPowerState != MODE_LOWPOWER || !anyWake
				|| (isWrite && cmd.addr == ADDR_POLL_CFG))
				gapValid <= 1'b0;
			else if (pollStrobe)
				gapValid <= 1'b1;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	sequence polledChange;
		pollHit && |(diff & wakeAll & ~compAll);
	endsequence
	sequence wakeOnce;
		wakeEvent && lowPowerState == MODE_NORMAL ##1 !wakeEvent;
	endsequence

	chk_resp_flags: assert property ( // RQ9
		respWord[FAULT_BIT] == faultStatus && respWord[INTFLAG_BIT] == interruptFlag)
		else $error("status flags misplaced in response");
	chk_unused_zero: assert property ( // RQ10
		respWord[REG_DATA_BITS-1:GND_CH] == '0
		&& ((prevAddr != ADDR_WAKE_PROG && prevAddr != ADDR_COMP_PROG
		&& prevAddr != ADDR_POLL_CFG) || respWord[GND_CH-1:PROG_CH] == '0))
		else $error("unused response bits not zero");
	chk_wake_write: assert property ( // RQ3
		isWrite && cmd.addr == ADDR_WAKE_GND |=> wakeGnd == $past(cmd.data[GND_CH-1:0]))
		else $error("wake enable write not taken");
	chk_wake_gated: assert property ( // RQ1
		lowPowerState == MODE_LOWPOWER && !anyWake |=> !wakeEvent)
		else $error("wake with all enables cleared");
	chk_poll_stop: assert property ( // RQ5
		lowPowerState == MODE_LOWPOWER && !anyWake |=> !pollStrobe && !pollTimerRun)
		else $error("poll timer running with no wake source");
	chk_poll_wake: assert property ( // RQ2
		polledChange |=> wakeOnce)
		else $error("enabled change did not wake");
	// State may go back to low power one cycle after the wake while the request stays high
	chk_comp_wake: assert property ( // RQ7
		compWake |=> wakeOnce)
		else $error("comparator-only change did not wake");
	chk_comp_nocurrent: assert property ( // RQ6
		(comparatorEn & pollCurrentEn) == '0)
		else $error("polling current on comparator-only channel");
	chk_poll_period: assert property ( // RQ11
		pollStrobe && gapValid |-> gapCnt == periodCycles - 23'h000001)
		else $error("poll interval does not match rate field");
endmodule : lwc_wake_config

// ### inc/lwc_pkg.sv
// Constants, frame layout and shared types of the low-power wake configuration block
// Contract
// RQ1: A cleared wake-enable bit keeps that channel from ending low-power state.
// RQ2: A set wake-enable bit lets that channel's change of state end low-power state.
// RQ3: Host may rewrite wake-enable registers any time in normal mode, always accepted.
// RQ4: After reset every implemented wake-enable bit reads one.
// RQ5: With every wake-enable bit cleared the polling timer stops in low-power state.
// RQ6: Comparator-only channels keep their comparator on with no polling current.
// RQ7: Comparator-only channels sample once per low-power clock and wake on change.
// RQ8: Comparator-only use suits inputs actively driven to 5.0 V, not switch contacts.
// RQ9: Responses carry fault in bit 23, interrupt flag in bit 22, data in 21..0.
// RQ10: Programmable channels on bits 7..0, ground-switch on 13..0, rest read zero.
// RQ11: A 4-bit polling-rate field sets the poll interval, reset value selects 64 ms.
package lwc_pkg;
	localparam int FRAME_BITS = 32;
	localparam int ADDR_BITS = 7;
	localparam int DATA_BITS = 24;
	localparam int REG_DATA_BITS = 22;
	localparam int PROG_CH = 8;
	localparam int GND_CH = 14;
	localparam int CHANNELS = PROG_CH + GND_CH;
	localparam int COUNT_BITS = 6;
	localparam int POLL_BITS = 23;
	localparam int FAULT_BIT = 23;
	localparam int INTFLAG_BIT = 22;
	// Register addresses as sent in frame bits 31..25
	localparam logic [ADDR_BITS-1:0] ADDR_POLL_CFG = 7'h0F;
	localparam logic [ADDR_BITS-1:0] ADDR_WAKE_PROG = 7'h10;
	localparam logic [ADDR_BITS-1:0] ADDR_WAKE_GND = 7'h11;
	localparam logic [ADDR_BITS-1:0] ADDR_COMP_PROG = 7'h12;
	localparam logic [ADDR_BITS-1:0] ADDR_COMP_GND = 7'h13;
	// Reset values
	localparam logic [PROG_CH-1:0] RST_WAKE_PROG = 8'hFF;
	localparam logic [GND_CH-1:0] RST_WAKE_GND = 14'h3FFF;
	localparam logic [PROG_CH-1:0] RST_COMP_PROG = 8'h00;
	localparam logic [GND_CH-1:0] RST_COMP_GND = 14'h0000;
	localparam logic [3:0] RST_POLL_RATE = 4'hF;
	// Timing
	localparam int CLK_FREQ_HZ = 25_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_FREQ_HZ / MS_PER_S;
	localparam int LP_CLK_CYCLES = 250;
	typedef logic [7:0] lwc_ms_t;
	// Poll interval in ms, indexed by the polling-rate field
	localparam lwc_ms_t POLL_MS [16] = '{8'h03, 8'h06, 8'h0C, 8'h18, 8'h30, 8'h44, 8'h4C,
		8'h80, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h34, 8'h38, 8'h3C, 8'h40};
	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic write;
		logic [DATA_BITS-1:0] data;
	} lwc_cmd_s;
	typedef enum logic {
		MODE_NORMAL = 1'b0,
		MODE_LOWPOWER = 1'b1
	} lwc_mode_e;
endpackage : lwc_pkg

// ### design/lwc_spi_frame.sv
// Serial frame engine: oversampled pins, 32-bit command in, response word out
`timescale 1ns/1ps
module lwc_spi_frame
	import lwc_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sclkPin,
	input wire logic csPinN,
	input wire logic mosiPin,
	input wire logic [FRAME_BITS-1:0] respWord,
	output lwc_cmd_s cmd,
	output logic cmdValid,
	output logic miso,
	output logic misoOe
);
	logic [2:0] sclkSync, next_sclkSync;
	logic [2:0] csSync, next_csSync;
	logic [1:0] mosiSync, next_mosiSync;
	logic [FRAME_BITS-1:0] shiftIn, next_shiftIn;
	logic [FRAME_BITS-1:0] shiftOut, next_shiftOut;
	logic [COUNT_BITS-1:0] count, next_count;
	lwc_cmd_s next_cmd;
	logic next_cmdValid, next_miso, next_misoOe;
	logic sclkRise, sclkFall, csFall, csRise;

	// Edges seen only after the second flop; SCLK must stay below core_clk/8
	assign sclkRise = sclkSync[1] && !sclkSync[2];
	assign sclkFall = !sclkSync[1] && sclkSync[2];
	assign csFall = !csSync[1] && csSync[2];
	assign csRise = csSync[1] && !csSync[2];

	// Capture on rising SCLK, shift out on falling, accept only whole frames
	always_comb
	begin
		next_sclkSync = {sclkSync[1:0], sclkPin};
		next_csSync = {csSync[1:0], csPinN};
		next_mosiSync = {mosiSync[0], mosiPin};
		next_shiftIn = shiftIn;
		next_shiftOut = shiftOut;
		next_count = count;
		next_cmd = cmd;
		next_cmdValid = 1'b0;
		next_miso = miso;
		next_misoOe = misoOe;
		if (csFall)
		begin
			next_shiftOut = respWord;
			next_miso = respWord[FRAME_BITS-1];
			next_misoOe = 1'b1;
			next_count = '0;
		end
		else if (!csSync[1])
		begin
			if (sclkRise)
			begin
				next_shiftIn = {shiftIn[FRAME_BITS-2:0], mosiSync[1]};
				if (count != '1)
					next_count = count + 6'h01; // Saturates so long frames stay invalid
			end
			if (sclkFall)
			begin
				next_shiftOut = {shiftOut[FRAME_BITS-2:0], 1'b0};
				next_miso = shiftOut[FRAME_BITS-2];
			end
		end
		if (csRise)
		begin
			next_misoOe = 1'b0;
			next_miso = 1'b0;
			if (count == COUNT_BITS'(FRAME_BITS))
			begin
				next_cmdValid = 1'b1;
				next_cmd = lwc_cmd_s'(shiftIn);
			end
		end
	end

	// State registers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclkSync <= 3'h0;
			csSync <= 3'h7;
			mosiSync <= 2'h0;
			shiftIn <= '0;
			shiftOut <= '0;
			count <= '0;
			cmd <= '0;
			cmdValid <= 1'b0;
			miso <= 1'b0;
			misoOe <= 1'b0;
		end
		else
		begin
			sclkSync <= next_sclkSync;
			csSync <= next_csSync;
			mosiSync <= next_mosiSync;
			shiftIn <= next_shiftIn;
			shiftOut <= next_shiftOut;
			count <= next_count;
			cmd <= next_cmd;
			cmdValid <= next_cmdValid;
			miso <= next_miso;
			misoOe <= next_misoOe;
		end
	end
endmodule : lwc_spi_frame

// ### verification/lwc_host_model.sv
// Host controller model that drives the serial port of the wake block
`timescale 1ns/1ps
module lwc_host_model
	import lwc_pkg::*;
(
	input wire logic core_clk,
	output logic sclkPin,
	output logic csPinN,
	output logic mosiPin,
	input wire logic miso
);
	// Idle bus: clock low, deselected
	initial
	begin
		sclkPin = 1'b0;
		csPinN = 1'b1;
		mosiPin = 1'b0;
	end

	// One frame MSB first; six core cycles per half period leaves margin over the sync
	task automatic xfer(input logic [FRAME_BITS-1:0] tx, input int n,
		output logic [FRAME_BITS-1:0] rx);
		rx = '0;
		csPinN <= 1'b0;
		for (int i = FRAME_BITS - 1; i >= FRAME_BITS - n; i--)
		begin
			mosiPin <= tx[i];
			repeat (6) @(posedge core_clk);
			sclkPin <= 1'b1;
			rx[i] = miso;
			repeat (6) @(posedge core_clk);
			sclkPin <= 1'b0;
		end
		repeat (6) @(posedge core_clk);
		csPinN <= 1'b1;
		// Released data line shows the inverse, never the stale bit
		mosiPin <= ~tx[FRAME_BITS - n];
		repeat (10) @(posedge core_clk);
	endtask : xfer
endmodule : lwc_host_model

// ### verification/test_lwc_wake_config.sv
// Self-checking bench for the wake configuration block
`timescale 1ns/1ps
module test_lwc_wake_config
	import lwc_pkg::*;
;
	localparam int MS_P = 4;
	localparam int LP_P = 5;
	logic core_clk, resetn, sclkPin, csPinN, mosiPin, miso, misoOe;
	logic faultStatus, interruptFlag, lowPowerReq;
	logic [PROG_CH-1:0] progSwitchPin;
	logic [GND_CH-1:0] gndSwitchPin;
	lwc_mode_e lowPowerState;
	lwc_mode_e stW;
	logic wakeEvent, pollTimerRun, pollStrobe, sawWake, sawStrobe;
	logic [CHANNELS-1:0] pollCurrentEn, comparatorEn, pcSeen;
	logic [FRAME_BITS-1:0] resp;
	int gap;
	int n_mismatch = 0;
	int n_checks = 0;

	lwc_wake_config #(.MS_CYCLES_P(MS_P), .LP_CLK_P(LP_P)) i_dut (.core_clk(core_clk),
		.resetn(resetn), .sclkPin(sclkPin), .csPinN(csPinN), .mosiPin(mosiPin), .miso(miso),
		.misoOe(misoOe), .faultStatus(faultStatus), .interruptFlag(interruptFlag),
		.lowPowerReq(lowPowerReq), .progSwitchPin(progSwitchPin),
		.gndSwitchPin(gndSwitchPin), .lowPowerState(lowPowerState), .wakeEvent(wakeEvent),
		.pollTimerRun(pollTimerRun), .pollStrobe(pollStrobe), .pollCurrentEn(pollCurrentEn),
		.comparatorEn(comparatorEn));
	lwc_host_model i_host (.core_clk(core_clk), .sclkPin(sclkPin), .csPinN(csPinN),
		.mosiPin(mosiPin), .miso(miso));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic frame(input logic [6:0] a, input logic w, input logic [23:0] d,
		input int n = 32);
		i_host.xfer({a, w, d}, n, resp);
	endtask : frame

	// Reply is pipelined, so the second frame returns what the first addressed
	task automatic rd(input logic [6:0] a, input logic [21:0] exp);
		frame(a, 1'b0, 24'h000000);
		frame(a, 1'b0, 24'h000000);
		chk("addr", 32'(a), 32'(resp[31:25]));
		chk("flags", 32'({faultStatus, interruptFlag}), 32'(resp[23:22]));
		chk("data", 32'(exp), 32'(resp[21:0]));
	endtask : rd

	// Watch outputs mid-cycle until a wake or the limit; state kept from the wake cycle
	task automatic watch(input int lim);
		int last;
		sawWake = 1'b0;
		sawStrobe = 1'b0;
		gap = 0;
		last = 0;
		for (int c = 0; c < lim && sawWake !== 1'b1; c++)
		begin
			@(negedge core_clk);
			sawWake = wakeEvent;
			stW = lowPowerState;
			if (pollStrobe === 1'b1)
			begin
				if (sawStrobe === 1'b1 && gap == 0)
					gap = c - last;
				sawStrobe = 1'b1;
				pcSeen = pollCurrentEn;
				last = c;
			end
		end
		@(posedge core_clk);
	endtask : watch

	task automatic t_reset;
		chk("oe idle", 32'h0, 32'(misoOe));
		rd(ADDR_WAKE_PROG, 22'h0000FF);
		rd(ADDR_WAKE_GND, 22'h003FFF);
		rd(ADDR_COMP_PROG, 22'h000000);
		rd(ADDR_COMP_GND, 22'h000000);
		rd(ADDR_POLL_CFG, 22'h00000F);
		// Short frame must leave the register alone
		frame(ADDR_WAKE_PROG, 1'b1, 24'h000000, 31);
		rd(ADDR_WAKE_PROG, 22'h0000FF);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_regs;
		logic [6:0] ad [4] = '{ADDR_WAKE_PROG, ADDR_WAKE_GND, ADDR_COMP_PROG, ADDR_COMP_GND};
		logic [21:0] mk [4] = '{22'h0000FF, 22'h003FFF, 22'h0000FF, 22'h003FFF};
		for (int i = 0; i < 4; i++)
		begin
			faultStatus <= i[0];
			interruptFlag <= i[1];
			frame(ad[i], 1'b1, 24'hFFFFFF);
			rd(ad[i], mk[i]);
			frame(ad[i], 1'b1, 24'h000000);
			rd(ad[i], 22'h000000);
		end
		rd(7'h7F, 22'h000000);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_wake;
		frame(ADDR_POLL_CFG, 1'b1, 24'h000000);
		frame(ADDR_WAKE_PROG, 1'b1, 24'h000001);
		lowPowerReq <= 1'b1;
		@(posedge core_clk);
		progSwitchPin <= 8'h02;
		watch(40);
		chk("wake off", 32'h0, 32'(sawWake));
		chk("gap", 32'(3 * MS_P), 32'(gap));
		chk("poll cur", 32'h3FFFFF, 32'(pcSeen));
		chk("timer", 32'h1, 32'(pollTimerRun));
		progSwitchPin <= 8'h03;
		watch(3 * MS_P + 6);
		chk("wake on", 32'h1, 32'(sawWake));
		chk("state", 32'(MODE_NORMAL), 32'(stW));
		lowPowerReq <= 1'b0;
		$display("t_wake done");
	endtask : t_wake

	task automatic t_nowake;
		frame(ADDR_WAKE_PROG, 1'b1, 24'h000000);
		lowPowerReq <= 1'b1;
		progSwitchPin <= 8'h00;
		watch(60);
		chk("no poll", 32'h0, 32'(sawStrobe));
		chk("timer", 32'h0, 32'(pollTimerRun));
		chk("state", 32'(MODE_LOWPOWER), 32'(stW));
		lowPowerReq <= 1'b0;
		watch(4);
		chk("leave", 32'(MODE_NORMAL), 32'(stW));
		chk("no wake", 32'h0, 32'(sawWake));
		$display("t_nowake done");
	endtask : t_nowake

	task automatic t_comp;
		frame(ADDR_POLL_CFG, 1'b1, 24'h00000F);
		frame(ADDR_WAKE_PROG, 1'b1, 24'h000004);
		frame(ADDR_COMP_PROG, 1'b1, 24'h000004);
		lowPowerReq <= 1'b1;
		watch(3);
		chk("comp en", 32'h000004, 32'(comparatorEn));
		progSwitchPin <= 8'h04;
		watch(LP_P + 5);
		chk("comp wake", 32'h1, 32'(sawWake));
		chk("no poll", 32'h0, 32'(sawStrobe));
		lowPowerReq <= 1'b0;
		watch(4);
		chk("comp off", 32'h0, 32'(comparatorEn));
		$display("t_comp done");
	endtask : t_comp

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// Clock at 25 MHz
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Reset, then the scenarios in turn
	initial
	begin
		resetn = 1'b0;
		faultStatus = 1'b0;
		interruptFlag = 1'b0;
		lowPowerReq = 1'b0;
		progSwitchPin = 8'h00;
		gndSwitchPin = 14'h0000;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_reset;
		t_regs;
		t_wake;
		t_nowake;
		t_comp;
		final_report;
	end

	// Watchdog, about three times the expected run
	initial
	begin
		repeat (60000) @(posedge core_clk);
		n_mismatch++;
		final_report;
	end
endmodule : test_lwc_wake_config
